//--- verilog/pic_pkg.sv
/*
 * Constants, register map and state types of the pulse interval
 * capture channel.
 * Assumes a single clock domain and a synchronous reset.
 */
package pic_pkg;

   // ****************************************
   // Register indices on the 4-bit register port
   // ****************************************
   localparam logic [3:0] PIC_REG_UNIT_CTRL = 4'h0;
   localparam logic [3:0] PIC_REG_PRESCALER = 4'h1;
   localparam logic [3:0] PIC_REG_NOISE_FILT = 4'h2;
   localparam logic [3:0] PIC_REG_MODE = 4'h3;
   localparam logic [3:0] PIC_REG_START = 4'h4;
   localparam logic [3:0] PIC_REG_STOP = 4'h5;
   localparam logic [3:0] PIC_REG_ENABLE = 4'h6;
   localparam logic [3:0] PIC_REG_COUNTER = 4'h7;
   localparam logic [3:0] PIC_REG_CAPTURE = 4'h8;
   localparam logic [3:0] PIC_REG_STATUS = 4'h9;
   localparam logic [3:0] PIC_REG_OUT_CTL = 4'hA;

   // ****************************************
   // Field positions
   // ****************************************
   localparam int PIC_UNIT_EN_BIT = 0;
   localparam int PIC_TRIG_BIT = 0;
   localparam int PIC_NF_EN_BIT = 0;
   localparam int PIC_OVF_BIT = 0;
   localparam int PIC_CKS_HI = 15;
   localparam int PIC_CKS_LO = 14;
   localparam int PIC_CCS_BIT = 12;
   localparam int PIC_MS_BIT = 11;
   localparam int PIC_STS_MSB = 10;
   localparam int PIC_STS_LSB = 8;
   localparam int PIC_CIS_MSB = 7;
   localparam int PIC_CIS_LSB = 6;
   localparam int PIC_MD_MSB = 3;
   localparam int PIC_MD_LSB = 1;
   localparam int PIC_MD0_BIT = 0;
   localparam int PIC_PSC_FIELD_W = 4;

   // ****************************************
   // Encodings and reset values
   // ****************************************
   localparam logic [2:0] PIC_MODE_CAPTURE = 3'h2;
   localparam logic [2:0] PIC_TRIG_PIN_EDGE = 3'h1;
   localparam logic [1:0] PIC_EDGE_FALL = 2'h0;
   localparam logic [1:0] PIC_EDGE_RISE = 2'h1;
   localparam logic [1:0] PIC_EDGE_BOTH = 2'h2;
   localparam logic [15:0] PIC_CIS_MASK = 16'h00C0;
   localparam logic [15:0] PIC_MODE_RST = 16'h0000;
   localparam logic [15:0] PIC_PSC_RST = 16'h0000;
   localparam logic [15:0] PIC_COUNT_ZERO = 16'h0000;
   localparam logic [15:0] PIC_COUNT_FULL = 16'hFFFF;

   typedef enum logic {PIC_CH_STOP, PIC_CH_RUN} pic_chan_state_t;

   typedef struct packed {
      logic unit_en;
      logic [15:0] psc;
      logic nf_en;
      logic [15:0] mode;
      logic [3:0] out_ctl;
      pic_chan_state_t state;
      logic [15:0] count;
      logic [15:0] cap;
      logic ovf;
      logic ovf_pend;
      logic irq;
      logic [15:0] rdata;
   } pic_chan_st_t;

endpackage

//--- verilog/pic_tick_if.sv
/*
 * Link between the channel and the shared prescaler: run enable,
 * prescaler setting and the four prescaled clock ticks.
 * Assumes both ends run on the same clock.
 */
`timescale 1ns/100ps
interface pic_tick_if;
   logic run;
   logic [15:0] psc;
   logic [3:0] tick;
   modport src (input run, input psc, output tick);
   modport dst (output run, output psc, input tick);
endinterface

//--- verilog/pic_prescaler.sv
/*
 * Prescaler making four tick pulses, each at clk / 2^field.
 * Assumes run is low while the unit is powered off.
 */
`timescale 1ns/100ps
module pic_prescaler
   import pic_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   pic_tick_if.src tk
);

   typedef struct packed {
      logic [15:0] cnt;
      logic [3:0] tick;
   } pic_psc_st_t;

   pic_psc_st_t s_reg;
   pic_psc_st_t s_next;

   function automatic logic [15:0] pic_div_mask(input logic [3:0] sel);
      pic_div_mask = 16'((17'h00001 << sel) - 17'h00001);
   endfunction

   // ****************************************
   // Tick generation
   // ****************************************
   always_comb begin
      s_next = s_reg;
      s_next.tick = 4'h0;
      if (tk.run) begin
         s_next.cnt = s_reg.cnt + 16'h0001;
         for (int k = 0; k < 4; k++) begin
            s_next.tick[k] = (s_reg.cnt & pic_div_mask(tk.psc[k*PIC_PSC_FIELD_W +: 4]))
               == pic_div_mask(tk.psc[k*PIC_PSC_FIELD_W +: 4]);
         end
      end else begin
         s_next.cnt = 16'h0000;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         s_reg <= '0;
      end else begin
         s_reg <= s_next;
      end
   end

   assign tk.tick = s_reg.tick;

endmodule // pic_prescaler

//--- verilog/pic_edge_detect.sv
/*
 * Input pin sampler, optional noise filter and valid edge detector.
 * Assumes the pin is synchronous to clk; samples on op_tick only.
 */
`timescale 1ns/100ps
module pic_edge_detect
   import pic_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic clear,
   input wire logic op_tick,
   input wire logic pin,
   input wire logic filt_en,
   input wire logic [1:0] edge_sel,
   output logic edge_pulse
);

   typedef struct packed {
      logic samp;
      logic level;
      logic primed;
      logic pulse;
   } pic_edge_st_t;

   pic_edge_st_t s_reg;
   pic_edge_st_t s_next;
   logic new_level;

   // ****************************************
   // Sampling and edge decode
   // ****************************************
   always_comb begin
      s_next = s_reg;
      s_next.pulse = 1'b0;
      new_level = s_reg.level;
      if (clear) begin
         s_next = '0;
      end else if (op_tick) begin
         s_next.samp = pin;
         // First sample after enable takes the pin as is, so no false edge
         if (filt_en && s_reg.primed) begin
            new_level = (s_reg.samp == pin) ? pin : s_reg.level;
         end else begin
            new_level = pin;
         end
         if (s_reg.primed && new_level != s_reg.level) begin
            case (edge_sel)
               PIC_EDGE_FALL: s_next.pulse = !new_level;
               PIC_EDGE_RISE: s_next.pulse = new_level;
               PIC_EDGE_BOTH: s_next.pulse = 1'b1;
               default: s_next.pulse = 1'b0;
            endcase
         end
         s_next.level = new_level;
         s_next.primed = 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         s_reg <= '0;
      end else begin
         s_reg <= s_next;
      end
   end

   assign edge_pulse = s_reg.pulse;

endmodule // pic_edge_detect

//--- verilog/pic_channel.sv
/*
 * Pulse interval capture channel with its unit enable, prescaler
 * and noise filter controls, reached over a plain register port.
 * Assumes the register master keeps strobes one cycle long and never
 * raises write and read together; the pin is synchronous to clk.
 */
// Design decisions made here: the register addresses and the address-and-strobe port.
// Notes on behaviour
// - Mode field 010B makes the channel a capture-mode up-counter.
// - Lowest mode bit set gives one interrupt when counting starts.
// - Edge select: 00B falling, 01B rising, 10B both; 11B is forbidden.
// - Trigger select 001B makes the valid pin edge the capture trigger.
// - Clock select 00B clock 0, 10B clock 1; 01B/11B only on some channels.
// - Unit disabled: clock stopped, writes ignored; enabling leaves channel stopped.
// - Prescaler register sets the rates of the four prescaled clocks.
// - Noise filter bit 0 bypasses the filter, 1 inserts it before edge detection.
// - Start trigger sets enable status, clears the counter, reads back 0.
// - While enabled, capture on edge or start: copy count, clear, interrupt.
// - Each capture sets overflow flag if the counter wrapped, else clears it.
// - Stop trigger clears enable, holds count and overflow flag, reads back 0.
// - Clearing unit enable initialises all unit and channel registers.
// - Pin is sampled on the operation clock, lagging up to one period.
// - Two or more wraps in an interval still show as one overflow.
`timescale 1ns/100ps
module pic_channel
   import pic_pkg::*;
#(
   parameter bit HAS_CLK23 = 1'b0
)
(
   input wire logic clk,
   input wire logic rst,
   input wire logic [3:0] reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [15:0] reg_rdata,
   input wire logic capture_input_pin,
   output logic chan_interrupt,
   output logic chan_enable_status
);

   pic_chan_st_t s_reg;
   pic_chan_st_t s_next;

   pic_tick_if tk ();

   logic [3:0] ticks;
   logic op_tick;
   logic edge_valid;
   logic running;
   logic cap_mode;
   logic wr_ok;
   logic start_wr;
   logic stop_wr;
   logic pin_trig;
   logic cap_evt;
   logic start_evt;
   logic count_tick;
   logic unit_off_wr;

   // ****************************************
   // Helpers
   // ****************************************
   function automatic logic [1:0] pic_clk_index(input logic [1:0] cks, input bit has23);
      case (cks)
         2'h0: pic_clk_index = 2'h0;
         2'h2: pic_clk_index = 2'h1;
         2'h1: pic_clk_index = has23 ? 2'h2 : 2'h0;
         2'h3: pic_clk_index = has23 ? 2'h3 : 2'h1;
         default: pic_clk_index = 2'h0;
      endcase
   endfunction

   function automatic logic pic_hit(input logic [3:0] addr, input logic [3:0] idx);
      pic_hit = (addr == idx);
   endfunction

   // ****************************************
   // Shared prescaler and pin edge detector
   // ****************************************
   assign tk.run = s_reg.unit_en;
   assign tk.psc = s_reg.psc;
   assign ticks = tk.tick;

   pic_prescaler pic_prescaler_inst (
      .clk (clk),
      .rst (rst),
      .tk (tk.src)
   );

   assign op_tick = ticks[pic_clk_index(s_reg.mode[PIC_CKS_HI:PIC_CKS_LO], HAS_CLK23)];

   pic_edge_detect pic_edge_detect_inst (
      .clk (clk),
      .rst (rst),
      .clear (!s_reg.unit_en),
      .op_tick (op_tick),
      .pin (capture_input_pin),
      .filt_en (s_reg.nf_en),
      .edge_sel (s_reg.mode[PIC_CIS_MSB:PIC_CIS_LSB]),
      .edge_pulse (edge_valid)
   );

   // ****************************************
   // Event decode
   // ****************************************
   assign running = (s_reg.state == PIC_CH_RUN);
   assign cap_mode = (s_reg.mode[PIC_MD_MSB:PIC_MD_LSB] == PIC_MODE_CAPTURE);
   assign wr_ok = reg_wr && s_reg.unit_en;
   assign start_wr = wr_ok && pic_hit(reg_addr, PIC_REG_START) && reg_wdata[PIC_TRIG_BIT];
   assign stop_wr = wr_ok && pic_hit(reg_addr, PIC_REG_STOP) && reg_wdata[PIC_TRIG_BIT];
   assign pin_trig = edge_valid && (s_reg.mode[PIC_STS_MSB:PIC_STS_LSB] == PIC_TRIG_PIN_EDGE);
   assign cap_evt = running && cap_mode && (pin_trig || start_wr);
   assign start_evt = !running && start_wr;
   assign count_tick = op_tick && !s_reg.mode[PIC_CCS_BIT];
   assign unit_off_wr = reg_wr && pic_hit(reg_addr, PIC_REG_UNIT_CTRL) &&
      !reg_wdata[PIC_UNIT_EN_BIT];

   // ****************************************
   // Next state
   // ****************************************
   always_comb begin
      s_next = s_reg;
      s_next.irq = 1'b0;
      s_next.rdata = 16'h0000;

      // Counting and wrap record
      if (running && cap_mode && count_tick) begin
         s_next.count = s_reg.count + 16'h0001;
         if (s_reg.count == PIC_COUNT_FULL) begin
            s_next.ovf_pend = 1'b1;
         end
      end

      // Capture beats counting in the same cycle
      if (cap_evt) begin
         s_next.cap = s_reg.count;
         s_next.count = PIC_COUNT_ZERO;
         s_next.ovf = s_reg.ovf_pend;
         s_next.ovf_pend = 1'b0;
         s_next.irq = 1'b1;
      end else if (start_evt) begin
         s_next.state = PIC_CH_RUN;
         s_next.count = PIC_COUNT_ZERO;
         s_next.ovf_pend = 1'b0;
         s_next.irq = s_reg.mode[PIC_MD0_BIT];
      end

      if (stop_wr && running) begin
         s_next.state = PIC_CH_STOP;
      end

      // Register writes
      if (wr_ok) begin
         case (reg_addr)
            PIC_REG_PRESCALER: s_next.psc = reg_wdata;
            PIC_REG_NOISE_FILT: s_next.nf_en = reg_wdata[PIC_NF_EN_BIT];
            PIC_REG_MODE: begin
               if (running) begin
                  s_next.mode = (s_reg.mode & ~PIC_CIS_MASK) | (reg_wdata & PIC_CIS_MASK);
               end else begin
                  s_next.mode = reg_wdata;
               end
            end
            PIC_REG_OUT_CTL: begin
               if (!running) begin
                  s_next.out_ctl = reg_wdata[3:0];
               end
            end
            default: s_next.out_ctl = s_next.out_ctl;
         endcase
      end
      if (reg_wr && pic_hit(reg_addr, PIC_REG_UNIT_CTRL) && reg_wdata[PIC_UNIT_EN_BIT]) begin
         s_next.unit_en = 1'b1;
      end

      // Reads; trigger registers read back zero
      if (reg_rd) begin
         case (reg_addr)
            PIC_REG_UNIT_CTRL: s_next.rdata = {15'h0000, s_reg.unit_en};
            PIC_REG_PRESCALER: s_next.rdata = s_reg.psc;
            PIC_REG_NOISE_FILT: s_next.rdata = {15'h0000, s_reg.nf_en};
            PIC_REG_MODE: s_next.rdata = s_reg.mode;
            PIC_REG_START: s_next.rdata = 16'h0000;
            PIC_REG_STOP: s_next.rdata = 16'h0000;
            PIC_REG_ENABLE: s_next.rdata = {15'h0000, running};
            PIC_REG_COUNTER: s_next.rdata = s_reg.count;
            PIC_REG_CAPTURE: s_next.rdata = s_reg.cap;
            PIC_REG_STATUS: s_next.rdata = {15'h0000, s_reg.ovf};
            PIC_REG_OUT_CTL: s_next.rdata = {12'h000, s_reg.out_ctl};
            default: s_next.rdata = 16'h0000;
         endcase
      end

      // Power-off returns everything to reset
      if (unit_off_wr) begin
         s_next = '0;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         s_reg <= '0;
      end else begin
         s_reg <= s_next;
      end
   end

   assign reg_rdata = s_reg.rdata;
   assign chan_interrupt = s_reg.irq;
   assign chan_enable_status = running;

   // ****************************************
   // Checks
   // ****************************************
   chk_start_clears: assert property (@(posedge clk) disable iff (rst)
      start_evt && !unit_off_wr |=> running && s_reg.count == PIC_COUNT_ZERO)
      else $error("start trigger did not enable and clear");

   chk_start_irq: assert property (@(posedge clk) disable iff (rst)
      start_evt |=> chan_interrupt == $past(s_reg.mode[PIC_MD0_BIT]))
      else $error("start interrupt does not follow mode bit");

   chk_capture_copy: assert property (@(posedge clk) disable iff (rst)
      cap_evt && !unit_off_wr |=> s_reg.cap == $past(s_reg.count) &&
      s_reg.count == PIC_COUNT_ZERO && chan_interrupt)
      else $error("capture did not copy, clear and interrupt");

   chk_ovf_update: assert property (@(posedge clk) disable iff (rst)
      cap_evt && !unit_off_wr |=> s_reg.ovf == $past(s_reg.ovf_pend))
      else $error("overflow flag not updated at capture");

   chk_wrap_record: assert property (@(posedge clk) disable iff (rst)
      running && cap_mode && count_tick && s_reg.count == PIC_COUNT_FULL &&
      !cap_evt && !unit_off_wr |=> s_reg.count == PIC_COUNT_ZERO && s_reg.ovf_pend)
      else $error("counter wrap not recorded");

   chk_stop_hold: assert property (@(posedge clk) disable iff (rst)
      stop_wr && running && !cap_evt |=> !running ##1 (($stable(s_reg.count) &&
      $stable(s_reg.ovf)) || $past(start_wr || unit_off_wr)))
      else $error("stop did not hold count and flag");

   chk_unit_off_init: assert property (@(posedge clk) disable iff (rst)
      unit_off_wr |=> !s_reg.unit_en && !running && s_reg.mode == PIC_MODE_RST &&
      s_reg.count == PIC_COUNT_ZERO && s_reg.psc == PIC_PSC_RST)
      else $error("unit power-off did not initialise");

   chk_writes_blocked: assert property (@(posedge clk) disable iff (rst)
      !s_reg.unit_en && reg_wr && !pic_hit(reg_addr, PIC_REG_UNIT_CTRL) |=>
      s_reg.mode == PIC_MODE_RST && !running)
      else $error("write accepted while unit is off");

   chk_pin_gated: assert property (@(posedge clk) disable iff (rst)
      edge_valid && !pin_trig && !start_wr |=> !chan_interrupt)
      else $error("edge captured with pin trigger not selected");

   chk_mode_gated: assert property (@(posedge clk) disable iff (rst)
      !cap_mode && !start_evt |=> !chan_interrupt)
      else $error("capture outside capture mode");

   cov_capture_ovf: cover property (@(posedge clk) disable iff (rst)
      cap_evt && s_reg.ovf_pend);
   cov_start_capture: cover property (@(posedge clk) disable iff (rst)
      start_evt ##[1:200] (cap_evt && edge_valid));
   cov_stop_run: cover property (@(posedge clk) disable iff (rst)
      stop_wr && running);

endmodule // pic_channel

//--- tb/pic_pulse_src.sv
/*
 * Pulse source model driving the capture input pin.
 * Assumes fire is a one-cycle request; the pin idles high and goes low
 * for width clock cycles, giving one falling and one rising edge.
 */
`timescale 1ns/100ps
module pic_pulse_src
(
   input wire logic clk,
   input wire logic rst,
   input wire logic fire,
   input wire logic [7:0] width,
   output logic pin
);
   logic [7:0] left_reg;
   // *****
   // Pin driven on clk only, so edges are synchronous
   // *****
   always_ff @(posedge clk) begin
      if (rst) begin
         left_reg <= 8'h00;
         pin <= 1'b1;
      end else if (fire) begin
         left_reg <= width - 8'h01;
         pin <= 1'b0;
      end else if (left_reg != 8'h00) begin
         left_reg <= left_reg - 8'h01;
      end else begin
         pin <= 1'b1;
      end
   end
endmodule // pic_pulse_src

//--- tb/pic_channel_tb.sv
/*
 * Self-checking bench of the capture channel over its register port.
 * Assumes pic_pkg, the design and the pulse source model are compiled first.
 */
`timescale 1ns/100ps
module pic_channel_tb
   import pic_pkg::*;
;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic [3:0] reg_addr = 4'h0;
   logic [15:0] reg_wdata = 16'h0000;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [15:0] reg_rdata;
   logic pin;
   logic chan_interrupt;
   logic chan_enable_status;
   logic fire = 1'b0;
   logic [7:0] width = 8'h01;
   int err_total = 0;
   int samples_checked = 0;
   int irq_cnt = 0;
   int i0;
   logic [15:0] v;
   logic [15:0] md;
   logic [15:0] lo;

   always #2 clk = ~clk;
   always @(posedge clk) begin
      if (chan_interrupt === 1'b1) irq_cnt <= irq_cnt + 1;
   end

   pic_channel #(.HAS_CLK23(1'b0)) pic_channel_inst (.clk(clk), .rst(rst),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .capture_input_pin(pin), .chan_interrupt(chan_interrupt),
      .chan_enable_status(chan_enable_status));
   pic_pulse_src pic_pulse_src_inst (.clk(clk), .rst(rst), .fire(fire), .width(width),
      .pin(pin));

   // *****
   // Access and compare tasks
   // *****
   task automatic tally_and_finish();
      $display("Comparisons %0d, mismatches %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      samples_checked++;
      if (got !== exp) begin
         err_total++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      reg_rd <= 1'b0;
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk);
   endtask

   task automatic nop(input int n);
      reg_wr <= 1'b0;
      reg_rd <= 1'b0;
      repeat (n) @(posedge clk);
   endtask

   task automatic rd(input logic [3:0] a, output logic [15:0] d);
      reg_wr <= 1'b0;
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_rd <= 1'b0;
      @(posedge clk);
      d = reg_rdata;
   endtask

   task automatic chk_rd(input logic [3:0] a, input logic [15:0] exp);
      logic [15:0] d;
      rd(a, d);
      chk(d, exp);
   endtask

   task automatic pulse(input logic [7:0] w, input int n);
      i0 = irq_cnt;
      reg_wr <= 1'b0;
      reg_rd <= 1'b0;
      fire <= 1'b1;
      width <= w;
      @(posedge clk);
      fire <= 1'b0;
      repeat (40) @(posedge clk);
      chk(16'(irq_cnt - i0), 16'(n));
   endtask

   // Count clock select and master/split bit always left at 0
   function automatic logic [15:0] mk(input logic [2:0] trg, input logic [1:0] edg,
      input logic [2:0] mode, input logic irq, input logic [1:0] cks);
      mk = 16'h0000;
      mk[PIC_CKS_HI:PIC_CKS_LO] = cks;
      mk[PIC_STS_MSB:PIC_STS_LSB] = trg;
      mk[PIC_CIS_MSB:PIC_CIS_LSB] = edg;
      mk[PIC_MD_MSB:PIC_MD_LSB] = mode;
      mk[PIC_MD0_BIT] = irq;
   endfunction

   // *****
   // Test sequence
   // *****
   initial begin
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      for (int i = 0; i < 12; i++) chk_rd(4'(i), 16'h0000);
      wr(PIC_REG_MODE, mk(3'h1, PIC_EDGE_FALL, PIC_MODE_CAPTURE, 1'b1, 2'h0));
      nop(1);
      chk_rd(PIC_REG_MODE, 16'h0000);
      wr(PIC_REG_UNIT_CTRL, 16'h0001);
      wr(PIC_REG_OUT_CTL, 16'h0000);
      wr(4'hF, 16'h1234);
      nop(1);
      chk_rd(PIC_REG_UNIT_CTRL, 16'h0001);
      chk_rd(PIC_REG_ENABLE, 16'h0000);
      chk_rd(4'hF, 16'h0000);
      for (int k = 0; k < 2; k++) begin
         wr(PIC_REG_PRESCALER, k ? 16'h0020 : 16'h0001);
         wr(PIC_REG_MODE, mk(3'h1, PIC_EDGE_FALL, PIC_MODE_CAPTURE, 1'b0, k ? 2'h2 : 2'h0));
         wr(PIC_REG_START, 16'h0001);
         nop(39);
         wr(PIC_REG_STOP, 16'h0001);
         nop(1);
         chk_rd(PIC_REG_PRESCALER, k ? 16'h0020 : 16'h0001);
         rd(PIC_REG_COUNTER, v);
         lo = k ? 16'h0009 : 16'h0013;
         samples_checked++;
         if (v < lo || v > lo + 16'h0002) begin
            err_total++;
            $display("Error at %0t: got %h expected %h", $time, v, lo + 16'h0001);
         end
      end
      wr(PIC_REG_PRESCALER, 16'h0000);
      wr(PIC_REG_MODE, mk(3'h1, PIC_EDGE_FALL, PIC_MODE_CAPTURE, 1'b1, 2'h0));
      i0 = irq_cnt;
      wr(PIC_REG_START, 16'h0001);
      nop(3);
      chk(16'(irq_cnt - i0), 16'h0001);
      chk_rd(PIC_REG_START, 16'h0000);
      chk_rd(PIC_REG_ENABLE, 16'h0001);
      chk(16'(chan_enable_status), 16'h0001);
      for (int m = 0; m < 5; m += 4) begin
         wr(PIC_REG_START, 16'h0001);
         if (m > 0) nop(m);
         wr(PIC_REG_START, 16'h0001);
         nop(1);
         chk_rd(PIC_REG_CAPTURE, 16'(m));
      end
      pulse(8'h1E, 1);
      md = mk(3'h1, PIC_EDGE_RISE, PIC_MODE_CAPTURE, 1'b1, 2'h0);
      wr(PIC_REG_MODE, md ^ 16'hF00F);
      nop(1);
      chk_rd(PIC_REG_MODE, md);
      pulse(8'h1E, 1);
      wr(PIC_REG_MODE, mk(3'h1, PIC_EDGE_BOTH, PIC_MODE_CAPTURE, 1'b1, 2'h0));
      pulse(8'h1E, 2);
      chk_rd(PIC_REG_CAPTURE, 16'h001D);
      pulse(8'h01, 2);
      wr(PIC_REG_NOISE_FILT, 16'h0001);
      pulse(8'h01, 0);
      pulse(8'h1E, 2);
      chk_rd(PIC_REG_CAPTURE, 16'h001D);
      wr(PIC_REG_OUT_CTL, 16'h000F);
      nop(1);
      chk_rd(PIC_REG_OUT_CTL, 16'h0000);
      wr(PIC_REG_STOP, 16'h0001);
      nop(1);
      chk_rd(PIC_REG_STOP, 16'h0000);
      chk_rd(PIC_REG_ENABLE, 16'h0000);
      chk(16'(chan_enable_status), 16'h0000);
      wr(PIC_REG_MODE, mk(3'h1, PIC_EDGE_BOTH, PIC_MODE_CAPTURE, 1'b0, 2'h0));
      i0 = irq_cnt;
      wr(PIC_REG_START, 16'h0001);
      nop(65545);
      chk(16'(irq_cnt - i0), 16'h0000);
      wr(PIC_REG_START, 16'h0001);
      nop(1);
      chk_rd(PIC_REG_STATUS, 16'h0001);
      chk_rd(PIC_REG_CAPTURE, 16'h0009);
      wr(PIC_REG_STOP, 16'h0001);
      nop(1);
      chk_rd(PIC_REG_STATUS, 16'h0001);
      chk_rd(PIC_REG_COUNTER, 16'h0006);
      nop(5);
      chk_rd(PIC_REG_COUNTER, 16'h0006);
      wr(PIC_REG_START, 16'h0001);
      wr(PIC_REG_START, 16'h0001);
      nop(1);
      chk_rd(PIC_REG_STATUS, 16'h0000);
      wr(PIC_REG_STOP, 16'h0001);
      for (int j = 0; j < 2; j++) begin
         wr(PIC_REG_MODE, j ? mk(3'h0, PIC_EDGE_BOTH, PIC_MODE_CAPTURE, 1'b0, 2'h0)
            : mk(3'h1, PIC_EDGE_BOTH, 3'h0, 1'b0, 2'h0));
         wr(PIC_REG_START, 16'h0001);
         nop(1);
         pulse(8'h1E, 0);
         wr(PIC_REG_STOP, 16'h0001);
      end
      wr(PIC_REG_UNIT_CTRL, 16'h0000);
      nop(1);
      for (int i = 0; i < 12; i++) chk_rd(4'(i), 16'h0000);
      tally_and_finish();
   end

   initial begin
      #400000;
      err_total++;
      $display("Error at %0t: watchdog got %h expected %h", $time, 16'h0001, 16'h0000);
      tally_and_finish();
   end
endmodule // pic_channel_tb
